// ===== hor_pkg.sv
// Package: register map, bit positions and reset values of the override bank
package hor_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] HOR_MON_FLAGS_OFS  = 8'h00;
  localparam logic [7:0] HOR_INPUT_RB_OFS   = 8'h02;
  localparam logic [7:0] HOR_PWR_CTRL_OFS   = 8'h12;
  localparam logic [7:0] HOR_CLAMP_CTRL_OFS = 8'h13;
  localparam logic [7:0] HOR_OUT_DRIVE_OFS  = 8'h1B;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int HOR_MONITOR5_BIT  = 0;
  localparam int HOR_MONITOR4_BIT  = 1;
  localparam int HOR_PON_RD_BIT    = 6;
  localparam int HOR_AC_RD_BIT     = 7;
  localparam int HOR_PON_WR_BIT    = 1;
  localparam int HOR_AC_WR_BIT     = 5;
  localparam int HOR_CLAMP_REL_BIT = 2;
  localparam int HOR_LATCH_CLR_BIT = 0;
  localparam int HOR_DRIVE_BIT     = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic HOR_PON_RST   = 1'b0;
  localparam logic HOR_AC_RST    = 1'b0;
  localparam logic HOR_CLAMP_RST = 1'b0;
  localparam logic HOR_DRIVE_RST = 1'b0;
  localparam logic HOR_LATCH_RST = 1'b0;
  localparam logic [7:0] HOR_RDATA_RST = 8'h00;
endpackage

// ===== hor_latch_if.sv
// Interface: carries alert/fail latch controls and state
`timescale 1ns/1ps
interface hor_latch_if;
  logic set;
  logic clr;
  logic q;
  modport ctl (output set, output clr, input q);
  modport lat (input set, input clr, output q);
endinterface

// ===== hor_alert_latch.sv
// Module: sticky alert/fail latch, set by faults, cleared by host command
`timescale 1ns/1ps
module hor_alert_latch
  import hor_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // Latch control
  hor_latch_if.lat  lat
);
  logic latch_q;

  // ****************************************
  // Latch: a fault in the clear cycle wins
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      latch_q <= HOR_LATCH_RST;
    end else if (lat.set) begin
      latch_q <= 1'b1;
    end else if (lat.clr) begin
      latch_q <= 1'b0;
    end
  end

  assign lat.q = latch_q;
endmodule

// ===== hor_override_bank.sv
// Module: host override register bank for the housekeeping controller
`timescale 1ns/1ps
module hor_override_bank
  import hor_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Register port from the serial management core
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Sensed pins
  input  wire logic       power_on_req_in,
  input  wire logic       ac_sense_input_one_in,
  input  wire logic       ac_sense_input_two_in,
  input  wire logic       monitor_input_five_in,
  input  wire logic       monitor_input_four_in,
  // Configuration and core events
  input  wire logic       host_mode_in,
  input  wire logic       pon_passthru_in,
  input  wire logic       ac_passthru_in,
  input  wire logic       default_release_in,
  input  wire logic       fault_in,
  // Controlled functions
  output logic            pon_debounce_src_out,
  output logic            power_on_cmd_out,
  output logic            ac_good_signal_function_out,
  output logic            clamp_release_out,
  output logic            alert_fail_out,
  output logic            smb_alert_out
);
  logic       host_pon;
  logic       host_ac;
  logic       host_clamp;
  logic       host_drive;
  logic       ac_sense;
  logic       wr_pwr;
  logic       wr_clamp;
  logic       wr_drive;
  logic [7:0] next_rdata;

  hor_latch_if latch_bus ();

  hor_alert_latch u_latch (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .lat        (latch_bus)
  );

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_pwr   = reg_wr_in && (reg_addr_in == HOR_PWR_CTRL_OFS);
  assign wr_clamp = reg_wr_in && (reg_addr_in == HOR_CLAMP_CTRL_OFS);
  assign wr_drive = reg_wr_in && (reg_addr_in == HOR_OUT_DRIVE_OFS);
  assign ac_sense = ac_sense_input_one_in | ac_sense_input_two_in;

  // ****************************************
  // Host power control
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      host_pon <= HOR_PON_RST;
      host_ac  <= HOR_AC_RST;
    end else if (wr_pwr) begin
      host_pon <= reg_wdata_in[HOR_PON_WR_BIT];
      host_ac  <= reg_wdata_in[HOR_AC_WR_BIT];
    end
  end

  // ****************************************
  // Clamp release and output drive
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      host_clamp <= HOR_CLAMP_RST;
    end else if (wr_clamp) begin
      host_clamp <= reg_wdata_in[HOR_CLAMP_REL_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      host_drive <= HOR_DRIVE_RST;
    end else if (wr_drive) begin
      host_drive <= reg_wdata_in[HOR_DRIVE_BIT];
    end
  end

  assign latch_bus.set = fault_in;
  assign latch_bus.clr = wr_clamp && reg_wdata_in[HOR_LATCH_CLR_BIT];

  // ****************************************
  // Function outputs
  // ****************************************
  // Without passthrough the pin is only sensed, never debounced here
  assign pon_debounce_src_out = pon_passthru_in & power_on_req_in;
  assign power_on_cmd_out = host_mode_in ? host_pon
                                         : pon_debounce_src_out;
  assign ac_good_signal_function_out = host_mode_in ? host_ac
                                           : (ac_passthru_in & ac_sense);
  assign clamp_release_out = host_clamp | default_release_in;
  assign alert_fail_out    = latch_bus.q | host_drive;
  assign smb_alert_out     = latch_bus.q;

  // ****************************************
  // Read path: write-only and unmapped read zero
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_in)
      HOR_MON_FLAGS_OFS: begin
        next_rdata[HOR_MONITOR5_BIT] = monitor_input_five_in;
        next_rdata[HOR_MONITOR4_BIT] = monitor_input_four_in;
      end
      HOR_INPUT_RB_OFS: begin
        next_rdata[HOR_PON_RD_BIT] = power_on_req_in;
        next_rdata[HOR_AC_RD_BIT]  = ac_sense;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= HOR_RDATA_RST;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  pon_read_a: assert property (
    reg_rd_in && reg_addr_in == HOR_INPUT_RB_OFS
    |=> reg_rdata_out[HOR_PON_RD_BIT] == $past(power_on_req_in))
    else $error("power-on readback wrong");

  ac_read_a: assert property (
    reg_rd_in && reg_addr_in == HOR_INPUT_RB_OFS
    |=> reg_rdata_out[HOR_AC_RD_BIT] ==
        $past(ac_sense_input_one_in | ac_sense_input_two_in))
    else $error("ac sense readback wrong");

  mon_read_a: assert property (
    reg_rd_in && reg_addr_in == HOR_MON_FLAGS_OFS
    |=> reg_rdata_out == {6'h00, $past(monitor_input_four_in),
                          $past(monitor_input_five_in)})
    else $error("monitor flags readback wrong");

  pon_write_a: assert property (
    host_mode_in && reg_wr_in && reg_addr_in == HOR_PWR_CTRL_OFS
    ##1 host_mode_in
    |-> power_on_cmd_out == $past(reg_wdata_in[HOR_PON_WR_BIT]))
    else $error("power-on command not taken");

  pon_gate_a: assert property (
    !pon_passthru_in |-> !pon_debounce_src_out)
    else $error("power-on pin leaked to debounce");

  ac_write_a: assert property (
    host_mode_in && reg_wr_in && reg_addr_in == HOR_PWR_CTRL_OFS
    ##1 host_mode_in
    |-> ac_good_signal_function_out == $past(reg_wdata_in[HOR_AC_WR_BIT]))
    else $error("ac_good_signal command not taken");

  clamp_rel_a: assert property (
    reg_wr_in && reg_addr_in == HOR_CLAMP_CTRL_OFS
    && reg_wdata_in[HOR_CLAMP_REL_BIT] |=> clamp_release_out)
    else $error("share clamp not released");

  drive_pin_a: assert property (
    reg_wr_in && reg_addr_in == HOR_OUT_DRIVE_OFS
    && reg_wdata_in[HOR_DRIVE_BIT] |=> alert_fail_out)
    else $error("fail pin not driven");

  fault_alert_a: assert property (
    fault_in |=> smb_alert_out [*2] or (smb_alert_out ##1 !fault_in))
    else $error("fault did not raise alert");

  latch_clear_a: assert property (
    reg_wr_in && reg_addr_in == HOR_CLAMP_CTRL_OFS
    && reg_wdata_in[HOR_LATCH_CLR_BIT] && !fault_in |=> !smb_alert_out)
    else $error("alert latch not cleared");

  ro_write_a: assert property (
    reg_rd_in && (reg_addr_in == HOR_PWR_CTRL_OFS
    || reg_addr_in == HOR_CLAMP_CTRL_OFS
    || reg_addr_in == HOR_OUT_DRIVE_OFS) |=> reg_rdata_out == 8'h00)
    else $error("write-only register read back");

  pon_off_c:   cover property (host_mode_in && $fell(power_on_cmd_out));
  clear_c:     cover property ($fell(smb_alert_out));
  drive_c:     cover property (alert_fail_out && !smb_alert_out);
  clamp_c:     cover property ($rose(clamp_release_out));
endmodule

// ===== hor_host_model.sv
// Host microcontroller model on the override register port
`timescale 1ns/1ps
module hor_host_model
  import hor_pkg::*;
(
  // Clock
  input  wire logic       clk_sys_in,
  // Register port
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'hA5;
    reg_wdata_out = 8'h5A;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // ****************************************
  // One register access, read data taken at the answer edge
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge clk_sys_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = w;
    reg_rd_out = !w;
    @(posedge clk_sys_in);
    #1;
    q = reg_rdata_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // Released lines must not keep the last value
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  // ****************************************
  // Poll twice, copy a settled change to the power bit
  // ****************************************
  task automatic follow_pon(input logic last, output logic now);
    logic [7:0] a;
    logic [7:0] b;
    xfer(1'b0, HOR_INPUT_RB_OFS, 8'h00, a);
    xfer(1'b0, HOR_INPUT_RB_OFS, 8'h00, b);
    now = last;
    if (a[6] === b[6] && a[6] !== last) begin
      now = a[6];
      xfer(1'b1, HOR_PWR_CTRL_OFS, {6'h00, now, 1'b0}, a);
    end
  endtask
endmodule

// ===== hor_override_bank_tb_top.sv
// Testbench for the host override register bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h seen %h", nm, e, s); miscompares++; end end
module hor_override_bank_tb_top;
  import hor_pkg::*;
  logic       clk_sys, rst_n, wr, rd, pon, ac1, ac2, mf5, mf4;
  logic       hm, ppt, apt, drl, fault, src, cmd, acok, clr, af, alrt;
  logic [7:0] addr, wdata, rdata, q;
  logic       st;
  int         miscompares = 0;
  int         n_tests = 0;
  logic [12:0] rows [4] = '{13'h0DAE, 13'h0351, 13'h0830, 13'h1DC8};
  hor_host_model i_host (.clk_sys_in(clk_sys), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdata));
  hor_override_bank i_dut (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .power_on_req_in(pon),
    .ac_sense_input_one_in(ac1), .ac_sense_input_two_in(ac2),
    .monitor_input_five_in(mf5), .monitor_input_four_in(mf4),
    .host_mode_in(hm), .pon_passthru_in(ppt), .ac_passthru_in(apt),
    .default_release_in(drl), .fault_in(fault),
    .pon_debounce_src_out(src), .power_on_cmd_out(cmd),
    .ac_good_signal_function_out(acok), .clamp_release_out(clr),
    .alert_fail_out(af), .smb_alert_out(alrt));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_sim();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    i_host.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial begin
    {rst_n, hm, ppt, apt, drl, pon, ac1, ac2, mf5, mf4, fault} = 11'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    `CHK("rdata rst", 8'h00, rdata)
    `CHK("alert rst", 2'h0, {af, alrt})
    // ****************************************
    // Table of pin and mode combinations
    // ****************************************
    for (int i = 0; i < 4; i++) begin
      tick();
      {hm, ppt, apt, drl, pon, ac1, ac2, mf5, mf4} = rows[i][12:4];
      #1;
      `CHK("outs", rows[i][3:0], {src, cmd, acok, clr})
      rd_reg(HOR_MON_FLAGS_OFS);
      `CHK("rd 00", {6'h00, mf4, mf5}, q)
      rd_reg(HOR_INPUT_RB_OFS);
      `CHK("rd 02", {ac1 | ac2, pon, 6'h00}, q)
    end
    // ****************************************
    // Host commands, refused accesses, latch
    // ****************************************
    wr_reg(HOR_PWR_CTRL_OFS, 8'h22);
    `CHK("pwr on", 2'h3, {cmd, acok})
    rd_reg(HOR_PWR_CTRL_OFS);
    `CHK("rd 12", 8'h00, q)
    wr_reg(HOR_PWR_CTRL_OFS, 8'h00);
    `CHK("pwr off", 2'h0, {cmd, acok})
    wr_reg(HOR_MON_FLAGS_OFS, 8'hFF);
    wr_reg(8'h05, 8'hFF);
    rd_reg(HOR_MON_FLAGS_OFS);
    `CHK("rd 00 ro", 8'h00, q)
    rd_reg(8'h05);
    `CHK("rd 05", 8'h00, q)
    wr_reg(HOR_CLAMP_CTRL_OFS, 8'h04);
    `CHK("clamp", 1'b1, clr)
    wr_reg(HOR_CLAMP_CTRL_OFS, 8'h00);
    `CHK("clamp off", 1'b0, clr)
    wr_reg(HOR_OUT_DRIVE_OFS, 8'h02);
    `CHK("drive", 2'h2, {af, alrt})
    wr_reg(HOR_OUT_DRIVE_OFS, 8'h00);
    `CHK("undrive", 2'h0, {af, alrt})
    tick();
    fault = 1'b1;
    tick();
    fault = 1'b0;
    `CHK("fault", 2'h3, {af, alrt})
    repeat (3) tick();
    `CHK("latched", 2'h3, {af, alrt})
    wr_reg(HOR_CLAMP_CTRL_OFS, 8'h01);
    `CHK("cleared", 2'h0, {af, alrt})
    // Fault present in the clear cycle: the set must win
    tick();
    fault = 1'b1;
    wr_reg(HOR_CLAMP_CTRL_OFS, 8'h01);
    fault = 1'b0;
    `CHK("set wins", 2'h3, {af, alrt})
    wr_reg(HOR_CLAMP_CTRL_OFS, 8'h01);
    `CHK("cleared 2", 2'h0, {af, alrt})
    // ****************************************
    // Host follows the request pin, mid-run reset
    // ****************************************
    i_host.follow_pon(1'b0, st);
    `CHK("follow on", 1'b1, cmd)
    tick();
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    `CHK("reset", 9'h000, {cmd, rdata})
    wr_reg(HOR_PWR_CTRL_OFS, 8'h02);
    tick();
    pon = 1'b0;
    i_host.follow_pon(1'b1, st);
    `CHK("follow off", 1'b0, cmd)
    end_sim();
  end
endmodule
